// File: shared/sio_pkg.sv
package sio_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [4:0] SIO_OFF_MODE  = 5'h00;
  localparam logic [4:0] SIO_OFF_CTRL0 = 5'h04;
  localparam logic [4:0] SIO_OFF_DIV   = 5'h08;
  localparam logic [4:0] SIO_OFF_CTRL1 = 5'h0c;
  localparam logic [4:0] SIO_OFF_TXBUF = 5'h10;
  localparam logic [4:0] SIO_OFF_RXBUF = 5'h14;
  localparam logic [4:0] SIO_OFF_IRQ   = 5'h18;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SIO_RST_MODE  = 8'h00;
  localparam logic [2:0] SIO_RST_CTRL0 = 3'h0;
  localparam logic [7:0] SIO_RST_DIV   = 8'h00;

  // ---------------------------------------------------------------------------
  // Mode field codes
  // ---------------------------------------------------------------------------
  localparam logic [2:0] SIO_MODE_OFF  = 3'h0;
  localparam logic [2:0] SIO_MODE_SYNC = 3'h1;
  localparam logic [2:0] SIO_MODE_U7   = 3'h4;
  localparam logic [2:0] SIO_MODE_U8   = 3'h5;
  localparam logic [2:0] SIO_MODE_U9   = 3'h6;

  // ---------------------------------------------------------------------------
  // Counts
  // ---------------------------------------------------------------------------
  localparam logic [3:0] SIO_SYNC_BITS   = 4'h8;
  localparam logic [3:0] SIO_OVERSAMPLE  = 4'hf;  // Last count of divide-by-16
  localparam logic [8:0] SIO_PRE_2       = 9'h001;
  localparam logic [8:0] SIO_PRE_16      = 9'h00f;
  localparam logic [8:0] SIO_PRE_64      = 9'h03f;
  localparam logic [8:0] SIO_PRE_512     = 9'h1ff;
  localparam int         SIO_CLK_HZ      = 20000000;

  // Transmitter states
  typedef enum logic [4:0] {
    SIO_ST_IDLE  = 5'b00001,
    SIO_ST_START = 5'b00010,
    SIO_ST_DATA  = 5'b00100,
    SIO_ST_PAR   = 5'b01000,
    SIO_ST_STOP  = 5'b10000
  } sio_tx_state_t;

endpackage

// File: src/sio_serial_channel.sv
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
module sio_serial_channel (
  input  wire logic        SYS_CLK_I,         // System clock, 20 MHz
  input  wire logic        RESET_I,           // Synchronous reset, active high
  input  wire logic [4:0]  AVS_ADDRESS_I,     // Byte address
  input  wire logic        AVS_READ_I,        // Read request
  input  wire logic        AVS_WRITE_I,       // Write request
  input  wire logic [31:0] AVS_WRITEDATA_I,   // Write data
  input  wire logic [3:0]  AVS_BYTEENABLE_I,  // Byte lanes
  output logic      [31:0] AVS_READDATA_O,    // Read data
  output logic             AVS_WAITREQUEST_O, // Stall
  input  wire logic        CLK_PIN_I,         // Shift clock / baud source pin
  input  wire logic        RXD_I,             // Serial data in
  input  wire logic        CTS_N_I,           // Clear to send, active low
  output logic             TXD_O,             // Serial data out
  output logic             RTS_N_O,           // Ready to receive, active low
  input  wire logic        TX_IRQ_ACK_I,      // Transmit request accepted
  input  wire logic        RX_IRQ_ACK_I,      // Receive request accepted
  output logic             TX_IRQ_O,          // Transmit request flag
  output logic             RX_IRQ_O           // Receive request flag
);
  import sio_pkg::*;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [2:0] clk_sync_reg;
  logic [1:0] rxd_sync_reg;
  logic [1:0] cts_sync_reg;

  // Two flops per pin; third clock stage only feeds the edge detector
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      clk_sync_reg <= 3'h7;
      rxd_sync_reg <= 2'h3;
      cts_sync_reg <= 2'h3;
    end
    else
    begin
      clk_sync_reg <= {clk_sync_reg[1:0], CLK_PIN_I};
      rxd_sync_reg <= {rxd_sync_reg[0], RXD_I};
      cts_sync_reg <= {cts_sync_reg[0], CTS_N_I};
    end
  end

  logic pin_rise;
  logic rxd_s;
  logic cts_n_s;
  assign pin_rise = clk_sync_reg[1] & ~clk_sync_reg[2];
  assign rxd_s    = rxd_sync_reg[1];
  assign cts_n_s  = cts_sync_reg[1];

  // ---------------------------------------------------------------------------
  // Bus slave: one wait state, then the answer
  // ---------------------------------------------------------------------------
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic        wr_fire;
  logic        rd_fire;

  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_reg;
  assign wr_fire           = AVS_WRITE_I & ack_reg;
  assign rd_fire           = AVS_READ_I & ack_reg;
  assign AVS_READDATA_O    = rdata_reg;

  // Ack alternates so every access sees exactly one stalled cycle
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
      ack_reg <= 1'b0;
    else
      ack_reg <= (AVS_READ_I | AVS_WRITE_I) & ~ack_reg;
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  logic [7:0] mode_reg;   // [2:0] mode, 3 ext clk, 4 two stop, 5 even, 6 parity en
  logic [2:0] ctrl0_reg;  // [1:0] count source, 2 RTS select
  logic [7:0] div_reg;
  logic       tx_en_reg;
  logic       rx_en_reg;
  logic [8:0] txbuf_reg;
  logic       lo_we;

  assign lo_we = wr_fire & AVS_BYTEENABLE_I[0];

  // Software-written configuration
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      mode_reg  <= SIO_RST_MODE;
      ctrl0_reg <= SIO_RST_CTRL0;
      div_reg   <= SIO_RST_DIV;
      tx_en_reg <= 1'b0;
      rx_en_reg <= 1'b0;
    end
    else if (lo_we)
    begin
      if (AVS_ADDRESS_I == SIO_OFF_MODE)
        mode_reg <= AVS_WRITEDATA_I[7:0];
      if (AVS_ADDRESS_I == SIO_OFF_CTRL0)
        ctrl0_reg <= AVS_WRITEDATA_I[2:0];
      if (AVS_ADDRESS_I == SIO_OFF_DIV)
        div_reg <= AVS_WRITEDATA_I[7:0];
      if (AVS_ADDRESS_I == SIO_OFF_CTRL1)
      begin
        tx_en_reg <= AVS_WRITEDATA_I[0];
        rx_en_reg <= AVS_WRITEDATA_I[2];
      end
    end
  end

  logic uart_mode;
  logic sync_mode;
  assign uart_mode = mode_reg[2] & (mode_reg[1:0] != 2'h3);
  assign sync_mode = mode_reg[2:0] == SIO_MODE_SYNC;

  // RTS low only while reception is enabled and RTS is selected
  assign RTS_N_O = ~(ctrl0_reg[2] & rx_en_reg);

  // ---------------------------------------------------------------------------
  // Baud generation
  // ---------------------------------------------------------------------------
  logic [8:0] pre_cnt_reg;
  logic [8:0] pre_last;
  logic       src_tick;
  logic [7:0] brg_cnt_reg;
  logic       brg_tick;
  logic [3:0] os_cnt_reg;
  logic       bit_tick;

  // Prescaler terminal count per count source
  always_comb
  begin
    unique case (ctrl0_reg[1:0])
      2'h0: pre_last = SIO_PRE_2;
      2'h1: pre_last = SIO_PRE_16;
      2'h2: pre_last = SIO_PRE_64;
      2'h3: pre_last = SIO_PRE_512;
    endcase
  end

  // External source ticks once per synced pin rising edge
  assign src_tick = mode_reg[3] ? pin_rise : (pre_cnt_reg == pre_last);
  assign brg_tick = src_tick & (brg_cnt_reg == 8'h00);
  assign bit_tick = brg_tick & (os_cnt_reg == SIO_OVERSAMPLE);

  // Free prescaler, divide by n+1, then by sixteen
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      pre_cnt_reg <= 9'h000;
      brg_cnt_reg <= 8'h00;
      os_cnt_reg  <= 4'h0;
    end
    else
    begin
      pre_cnt_reg <= (pre_cnt_reg == pre_last) ? 9'h000 : pre_cnt_reg + 9'h001;
      if (src_tick)
        brg_cnt_reg <= (brg_cnt_reg == 8'h00) ? div_reg : brg_cnt_reg - 8'h01;
      if (brg_tick)
        os_cnt_reg <= os_cnt_reg + 4'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // Asynchronous transmitter
  // ---------------------------------------------------------------------------
  sio_tx_state_t st_reg;
  logic [8:0]    sh_reg;
  logic [3:0]    cnt_reg;
  logic          par_reg;
  logic          txd_reg;
  logic          tbe_reg;
  logic          tsre_reg;
  logic          tx_irq_reg;
  logic          can_start;
  logic          load;
  logic [3:0]    nbits;
  logic          buf_we;

  assign buf_we    = lo_we & (AVS_ADDRESS_I == SIO_OFF_TXBUF);
  assign can_start = uart_mode & tx_en_reg & ~tbe_reg
                   & (ctrl0_reg[2] | ~cts_n_s);
  assign load      = bit_tick & can_start
                   & ((st_reg == SIO_ST_IDLE)
                   | ((st_reg == SIO_ST_STOP) & (cnt_reg == 4'h0)));
  assign nbits     = (mode_reg[2:0] == SIO_MODE_U7) ? 4'h7 :
                     (mode_reg[2:0] == SIO_MODE_U8) ? 4'h8 : 4'h9;
  assign TXD_O     = txd_reg;

  // Transmit buffer holds nine bits; bit 8 arrives on lane 1
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
      txbuf_reg <= 9'h000;
    else if (buf_we)
      txbuf_reg <= {AVS_BYTEENABLE_I[1] ? AVS_WRITEDATA_I[8] : txbuf_reg[8],
                    AVS_WRITEDATA_I[7:0]};
  end

  // Buffer empty: write clears, load sets; load wins if both land together,
  // so a word written into a full buffer as it drains is dropped
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
      tbe_reg <= 1'b1;
    else if (load)
      tbe_reg <= 1'b1;
    else if (buf_we)
      tbe_reg <= 1'b0;
  end

  // Frame sequencer; line held high whenever no frame runs
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      st_reg   <= SIO_ST_IDLE;
      sh_reg   <= 9'h000;
      cnt_reg  <= 4'h0;
      par_reg  <= 1'b0;
      txd_reg  <= 1'b1;
      tsre_reg <= 1'b1;
    end
    else if (load)
    begin
      // Seven-bit mode ignores bit 7; ninth bit only in nine-bit mode
      sh_reg   <= {mode_reg[2:0] == SIO_MODE_U9 ? txbuf_reg[8] : 1'b0,
                   txbuf_reg[7:0]};
      cnt_reg  <= nbits - 4'h1;
      par_reg  <= ~mode_reg[5];
      st_reg   <= SIO_ST_START;
      txd_reg  <= 1'b0;
      tsre_reg <= 1'b0;
    end
    else if (bit_tick)
    begin
      unique case (st_reg)
        SIO_ST_IDLE:
          txd_reg <= 1'b1;
        SIO_ST_START:
        begin
          st_reg  <= SIO_ST_DATA;
          txd_reg <= sh_reg[0];
          par_reg <= par_reg ^ sh_reg[0];
          sh_reg  <= {1'b0, sh_reg[8:1]};
        end
        SIO_ST_DATA:
        begin
          if (cnt_reg == 4'h0)
          begin
            st_reg  <= mode_reg[6] ? SIO_ST_PAR : SIO_ST_STOP;
            txd_reg <= mode_reg[6] ? par_reg : 1'b1;
            cnt_reg <= (mode_reg[4] & ~mode_reg[6]) ? 4'h1 : 4'h0;
          end
          else
          begin
            cnt_reg <= cnt_reg - 4'h1;
            txd_reg <= sh_reg[0];
            par_reg <= par_reg ^ sh_reg[0];
            sh_reg  <= {1'b0, sh_reg[8:1]};
          end
        end
        SIO_ST_PAR:
        begin
          st_reg  <= SIO_ST_STOP;
          txd_reg <= 1'b1;
          cnt_reg <= mode_reg[4] ? 4'h1 : 4'h0;
        end
        SIO_ST_STOP:
        begin
          if (cnt_reg == 4'h0)
          begin
            st_reg   <= SIO_ST_IDLE;
            tsre_reg <= 1'b1;
          end
          else
            cnt_reg <= cnt_reg - 4'h1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Synchronous receiver, external shift clock
  // ---------------------------------------------------------------------------
  logic [7:0] rsh_reg;
  logic [3:0] rcnt_reg;
  logic [7:0] rxbuf_reg;
  logic       rdone_reg;
  logic       ovr_reg;
  logic       rx_irq_reg;
  logic       shift_en;
  logic       byte_done;
  logic       rxbuf_rd;

  assign shift_en  = sync_mode & mode_reg[3] & tx_en_reg & rx_en_reg & pin_rise;
  assign byte_done = shift_en & (rcnt_reg == SIO_SYNC_BITS - 4'h1);
  assign rxbuf_rd  = rd_fire & (AVS_ADDRESS_I == SIO_OFF_RXBUF);

  // Shift right with the new bit entering at the top
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      rsh_reg   <= 8'h00;
      rcnt_reg  <= 4'h0;
      rxbuf_reg <= 8'h00;
    end
    else if (~(tx_en_reg & rx_en_reg))
      rcnt_reg <= 4'h0;
    else if (shift_en)
    begin
      rsh_reg  <= {rxd_s, rsh_reg[7:1]};
      rcnt_reg <= byte_done ? 4'h0 : rcnt_reg + 4'h1;
      if (byte_done)
        rxbuf_reg <= {rxd_s, rsh_reg[7:1]};
    end
  end

  // Completion and overrun; a new byte wins over a same-cycle clear
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      rdone_reg <= 1'b0;
      ovr_reg   <= 1'b0;
    end
    else
    begin
      if (byte_done)
        rdone_reg <= 1'b1;
      else if (rxbuf_rd)
        rdone_reg <= 1'b0;
      if (byte_done & rdone_reg)
        ovr_reg <= 1'b1;
      else if (rxbuf_rd | ~rx_en_reg)
        ovr_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Request flags: set wins over acceptance or software clear
  // ---------------------------------------------------------------------------
  logic irq_clr_we;
  assign irq_clr_we = lo_we & (AVS_ADDRESS_I == SIO_OFF_IRQ);
  assign TX_IRQ_O   = tx_irq_reg;
  assign RX_IRQ_O   = rx_irq_reg;

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      tx_irq_reg <= 1'b0;
      rx_irq_reg <= 1'b0;
    end
    else
    begin
      if (load)
        tx_irq_reg <= 1'b1;
      else if (TX_IRQ_ACK_I | (irq_clr_we & AVS_WRITEDATA_I[0]))
        tx_irq_reg <= 1'b0;
      if (byte_done)
        rx_irq_reg <= 1'b1;
      else if (RX_IRQ_ACK_I | (irq_clr_we & AVS_WRITEDATA_I[1]))
        rx_irq_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data, captured in the stalled cycle
  // ---------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
      rdata_reg <= 32'h0000_0000;
    else if (AVS_READ_I & ~ack_reg)
    begin
      unique case (AVS_ADDRESS_I)
        SIO_OFF_MODE:  rdata_reg <= {24'h000000, mode_reg};
        SIO_OFF_CTRL0: rdata_reg <= {28'h0000000, tsre_reg, ctrl0_reg};
        SIO_OFF_DIV:   rdata_reg <= {24'h000000, div_reg};
        SIO_OFF_CTRL1: rdata_reg <= {24'h000000, ovr_reg, 2'h0, ovr_reg,
                                     rdone_reg, rx_en_reg, tbe_reg, tx_en_reg};
        SIO_OFF_TXBUF: rdata_reg <= {23'h000000, txbuf_reg};
        SIO_OFF_RXBUF: rdata_reg <= {24'h000000, rxbuf_reg};
        SIO_OFF_IRQ:   rdata_reg <= {30'h00000000, rx_irq_reg, tx_irq_reg};
        default:       rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_rts;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (ctrl0_reg[2] && $rose(rx_en_reg)) |-> !RTS_N_O;
  endproperty
  a_rts: assert property (p_rts) else $error("RTS not low when enabled");

  property p_rx_done;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    byte_done |=> rdone_reg && rx_irq_reg
                  && rxbuf_reg == (($past(rsh_reg) >> 1) | {$past(rxd_s), 7'h00});
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("byte not delivered");

  property p_rx_clear;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (rxbuf_rd && !byte_done) |=> !rdone_reg;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("completion not cleared");

  property p_overrun;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (byte_done && rdone_reg) |=> ovr_reg && rdone_reg;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");

  property p_gate;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    !tx_en_reg |=> $stable(rsh_reg);
  endproperty
  a_gate: assert property (p_gate) else $error("shift without enable");

  property p_start_low;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    load |=> !TXD_O && st_reg == SIO_ST_START && tbe_reg && !tsre_reg && tx_irq_reg;
  endproperty
  a_start_low: assert property (p_start_low) else $error("bad frame start");

  property p_idle_high;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (st_reg == SIO_ST_IDLE || st_reg == SIO_ST_STOP) |-> TXD_O;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low outside frame");

  property p_buf_clear;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (buf_we && !load) |=> !tbe_reg;
  endproperty
  a_buf_clear: assert property (p_buf_clear) else $error("buffer empty not cleared");

  property p_cts;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (load && !ctrl0_reg[2]) |-> !cts_n_s && tx_en_reg;
  endproperty
  a_cts: assert property (p_cts) else $error("start without CTS");

  c_frame:   cover property (@(posedge SYS_CLK_I) disable iff (RESET_I) load ##[1:800] tsre_reg);
  c_b2b:     cover property (@(posedge SYS_CLK_I) disable iff (RESET_I)
                             load && st_reg == SIO_ST_STOP);
  c_rx_byte: cover property (@(posedge SYS_CLK_I) disable iff (RESET_I) byte_done);
  c_ovr:     cover property (@(posedge SYS_CLK_I) disable iff (RESET_I) byte_done && rdone_reg);

endmodule

// File: testbench/sio_far_end.sv
module sio_far_end (
  input  wire logic SYS_CLK_I, // System clock
  input  wire logic TXD_I,     // Line from the block
  output logic      CLK_PIN_O, // Shift clock into the block
  output logic      RXD_O,     // Line into the block
  output logic      CTS_N_O    // Clear to send, active low
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle pins; always ready to take a frame
  initial
  begin
    CLK_PIN_O = 1'b1;
    RXD_O     = 1'b1;
    CTS_N_O   = 1'b0;
  end
  // Shift clock runs only inside a byte, LSB first
  task automatic send_sync(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge SYS_CLK_I);
      CLK_PIN_O <= 1'b0;
      RXD_O     <= b[i];
      repeat (8) @(posedge SYS_CLK_I);
      CLK_PIN_O <= 1'b1;
      repeat (8) @(posedge SYS_CLK_I);
    end
    RXD_O <= ~b[7]; // Released line must not echo the last bit
  endtask
  // Mid-bit sampler, bounded wait for the start edge
  task automatic take_frame(input int bc, input int nb, output logic [11:0] f);
    int w;
    w = 0;
    f = '0;
    while (TXD_I !== 1'b0 && w < 5000)
    begin
      @(posedge SYS_CLK_I);
      w++;
    end
    repeat (bc / 2) @(posedge SYS_CLK_I);
    for (int i = 0; i < nb; i++)
    begin
      f[i] = TXD_I;
      repeat (bc) @(posedge SYS_CLK_I);
    end
  endtask
endmodule

// File: testbench/tb_serial_io_uart_sync_port.sv
module tb_serial_io_uart_sync_port import sio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, rd, wr, wq, cpin, rxd, cts_n, txd, rts_n;
  logic        tx_ack, rx_ack, tx_irq, rx_irq;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata;
  int          n_fail, checked, cycles;
  // ----
  // Clock, watchdog, instances
  // ----
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard, far above the expected run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  sio_serial_channel sio_serial_channel_inst (.SYS_CLK_I(clk), .RESET_I(rst),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
    .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wq),
    .CLK_PIN_I(cpin), .RXD_I(rxd), .CTS_N_I(cts_n), .TXD_O(txd), .RTS_N_O(rts_n),
    .TX_IRQ_ACK_I(tx_ack), .RX_IRQ_ACK_I(rx_ack), .TX_IRQ_O(tx_irq), .RX_IRQ_O(rx_irq));
  sio_far_end sio_far_end_inst (.SYS_CLK_I(clk), .TXD_I(txd), .CLK_PIN_O(cpin),
    .RXD_O(rxd), .CTS_N_O(cts_n));
  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= ~w;
    @(posedge clk);
    while (wq !== 1'b0)
      @(posedge clk);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    // Outputs settle before the caller looks at them
    @(negedge clk);
  endtask
  task automatic give_verdict();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_uart(input logic [7:0] m, input logic [8:0] v, input logic [7:0] dv,
                        input int nb, input logic [11:0] e);
    logic [31:0] q;
    logic [11:0] f;
    bus(1'b1, SIO_OFF_CTRL1, 32'h0, q);
    bus(1'b1, SIO_OFF_MODE, {24'h0, m}, q);
    bus(1'b1, SIO_OFF_DIV, {24'h0, dv}, q);
    bus(1'b1, SIO_OFF_TXBUF, {23'h0, v}, q);
    bus(1'b0, SIO_OFF_CTRL1, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b1, SIO_OFF_CTRL1, 32'h1, q);
    sio_far_end_inst.take_frame(32 * (dv + 1), nb, f);
    chk({20'h0, f}, {20'h0, e});
    bus(1'b0, SIO_OFF_CTRL1, 32'h0, q);
    chk(q, 32'h3);
    chk({31'h0, tx_irq}, 32'h1);
    @(posedge clk);
    tx_ack <= 1'b1;
    @(posedge clk);
    tx_ack <= 1'b0;
    @(negedge clk);
    chk({31'h0, tx_irq}, 32'h0);
    repeat (40 * (dv + 1)) @(posedge clk);
    bus(1'b0, SIO_OFF_CTRL0, 32'h0, q);
    chk(q, 32'h8);
    chk({31'h0, txd}, 32'h1);
    $display("uart frame test done");
  endtask
  task automatic t_sync();
    logic [31:0] q;
    bus(1'b1, SIO_OFF_MODE, 32'h9, q);
    bus(1'b1, SIO_OFF_CTRL0, 32'h4, q);
    bus(1'b1, SIO_OFF_CTRL1, 32'h5, q);
    chk({31'h0, rts_n}, 32'h0);
    sio_far_end_inst.send_sync(8'h3c);
    repeat (6) @(negedge clk);
    chk({31'h0, rx_irq}, 32'h1);
    bus(1'b0, SIO_OFF_CTRL1, 32'h0, q);
    chk(q, 32'h0f);
    // Acceptance pulse drops the receive request
    @(posedge clk);
    rx_ack <= 1'b1;
    @(posedge clk);
    rx_ack <= 1'b0;
    @(negedge clk);
    chk({31'h0, rx_irq}, 32'h0);
    sio_far_end_inst.send_sync(8'hc3);
    repeat (6) @(negedge clk);
    bus(1'b0, SIO_OFF_CTRL1, 32'h0, q);
    chk(q, 32'h9f);
    bus(1'b0, SIO_OFF_RXBUF, 32'h0, q);
    chk(q, 32'hc3);
    bus(1'b0, SIO_OFF_CTRL1, 32'h0, q);
    chk(q, 32'h07);
    chk({31'h0, rx_irq}, 32'h1);
    bus(1'b1, SIO_OFF_IRQ, 32'h2, q);
    chk({31'h0, rx_irq}, 32'h0);
    bus(1'b0, 5'h1c, 32'h0, q);
    chk(q, 32'h0);
    // Unused mode code must not start a frame from a full buffer
    bus(1'b1, SIO_OFF_MODE, 32'h7, q);
    bus(1'b1, SIO_OFF_TXBUF, 32'h55, q);
    repeat (100) @(posedge clk);
    bus(1'b0, SIO_OFF_CTRL1, 32'h0, q);
    chk(q, 32'h05);
    chk({31'h0, txd}, 32'h1);
    $display("sync receive test done");
  endtask
  // Reset with bus and acknowledge inputs idle, then each scenario
  initial
  begin
    rst    = 1'b1;
    rd     = 1'b0;
    wr     = 1'b0;
    addr   = 5'h0;
    wdata  = 32'h0;
    tx_ack = 1'b0;
    rx_ack = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_uart(8'h65, 9'h0a5, 8'h0, 11, {2'b01, 1'b0, 8'ha5, 1'b0});
    t_uart(8'h54, 9'h041, 8'h1, 11, {1'b0, 2'b11, 1'b1, 7'h41, 1'b0});
    t_uart(8'h16, 9'h13c, 8'h0, 12, {2'b11, 9'h13c, 1'b0});
    t_sync();
    give_verdict();
  end
endmodule
